//--- adcpo_pkg.sv
package adcpo_pkg;

  // sample word geometry
  localparam int unsigned ADCPO_SAMPLE_W = 13;
  localparam int unsigned ADCPO_INPUT_W  = 16;

  // pipeline depth in sampling-clock cycles, rising edge to captured word
  localparam int unsigned ADCPO_LATENCY = 4;

  // offset binary code points
  localparam logic [12:0] ADCPO_CODE_MIN = 13'h0000;
  localparam logic [12:0] ADCPO_CODE_MID = 13'h1000;
  localparam logic [12:0] ADCPO_CODE_MAX = 13'h1FFF;

  // input span that converts without clipping, in lsb steps around common mode
  localparam logic signed [15:0] ADCPO_IN_HI     = 16'sh0FFF;
  localparam logic signed [15:0] ADCPO_IN_LO     = 16'shF000;
  localparam logic signed [15:0] ADCPO_IN_OFFSET = 16'sh1000;

  // values after reset
  localparam logic [12:0] ADCPO_WORD_RST  = 13'h0000;
  localparam logic [15:0] ADCPO_INPUT_RST = 16'h0000;

  // nominal output timing, picoseconds; far below one cycle of either clock
  localparam int unsigned ADCPO_T_DR_PS = 1100;

endpackage : adcpo_pkg

//--- adcpo_sync2.sv
// two-stage level synchroniser with asynchronous reset to zero
module adcpo_sync2 (
  // clock and reset of the receiving domain
  input  wire logic clk_i,
  input  wire logic rst_i,
  // level in, synchronised level out
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } adcpo_sync_state_t;

  adcpo_sync_state_t st_r;
  adcpo_sync_state_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = d_i;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.sync;

endmodule // adcpo_sync2

//--- adcpo_output_if.sv
module adcpo_output_if (
  // system clock and reset
  input  wire logic                                        clk_i,
  input  wire logic                                        sys_rst_i,
  // input level, signed lsb steps from common mode, system domain
  input  wire logic signed [adcpo_pkg::ADCPO_INPUT_W-1:0]  analog_input_pair_i,
  // sampling clock, free running
  input  wire logic                                        samp_clk_i,
  // parallel output, bit 0 is sample_bit_lsb, bit 12 is sample_bit_msb
  output logic             [adcpo_pkg::ADCPO_SAMPLE_W-1:0] sample_word_o,
  output logic                                             overrange_flag_o,
  output logic                                             word_valid_strobe_o
);
  import adcpo_pkg::*;

  // system-domain state: held input word and request toggle
  typedef struct packed {
    logic [ADCPO_INPUT_W-1:0] held;
    logic                     req_tgl;
  } adcpo_sys_state_t;

  // sampling-clock rising-edge state
  typedef struct packed {
    logic                                          ack_tgl;
    logic [ADCPO_INPUT_W-1:0]                      latest;
    logic [ADCPO_LATENCY-1:0][ADCPO_SAMPLE_W-1:0]  word;
    logic [ADCPO_LATENCY-1:0]                      overrange_flag;
    logic                                          rise_tgl;
  } adcpo_pos_state_t;

  // sampling-clock falling-edge state: the output pins
  typedef struct packed {
    logic [ADCPO_SAMPLE_W-1:0] word;
    logic                      overrange_flag;
    logic                      fall_tgl;
  } adcpo_neg_state_t;

  adcpo_sys_state_t sys_r;
  adcpo_sys_state_t sys_nxt;
  adcpo_pos_state_t pos_r;
  adcpo_pos_state_t pos_nxt;
  adcpo_neg_state_t neg_r;
  adcpo_neg_state_t neg_nxt;

  logic link_rst_n;
  logic link_rst;
  logic req_sync;
  logic ack_sync;

  // clip and offset one input value into a code plus over-range bit
  function automatic logic [ADCPO_SAMPLE_W:0] adcpo_convert(
    input logic signed [ADCPO_INPUT_W-1:0] v
  );
    logic signed [ADCPO_INPUT_W-1:0] shifted;
    shifted = v + ADCPO_IN_OFFSET; // common mode lands on mid-scale
    if (v > ADCPO_IN_HI) begin
      adcpo_convert = {1'b1, ADCPO_CODE_MAX};
    end else if (v < ADCPO_IN_LO) begin
      adcpo_convert = {1'b1, ADCPO_CODE_MIN};
    end else begin
      adcpo_convert = {1'b0, shifted[ADCPO_SAMPLE_W-1:0]};
    end
  endfunction

  // link-domain reset: asserts at once, releases on the sampling clock
  adcpo_sync2 u_rst_sync (
    .clk_i (samp_clk_i),
    .rst_i (sys_rst_i),
    .d_i   (1'b1),
    .q_o   (link_rst_n)
  );
  assign link_rst = ~link_rst_n;

  // request toggle into the sampling domain
  adcpo_sync2 u_req_sync (
    .clk_i (samp_clk_i),
    .rst_i (link_rst),
    .d_i   (sys_r.req_tgl),
    .q_o   (req_sync)
  );

  // acknowledge toggle back into the system domain
  adcpo_sync2 u_ack_sync (
    .clk_i (clk_i),
    .rst_i (sys_rst_i),
    .d_i   (pos_r.ack_tgl),
    .q_o   (ack_sync)
  );

  // system side: the held word changes only while no request is open,
  // so the sampling side always copies a stable word
  always_comb begin
    sys_nxt = sys_r;
    if (sys_r.req_tgl == ack_sync) begin
      sys_nxt.held    = analog_input_pair_i;
      sys_nxt.req_tgl = ~sys_r.req_tgl;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sys_r <= '{held: ADCPO_INPUT_RST, req_tgl: 1'b0};
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // rising edge: sample, convert, shift through the pipeline
  always_comb begin
    logic [ADCPO_SAMPLE_W:0] conv;
    conv    = adcpo_convert(pos_r.latest);
    pos_nxt = pos_r;
    if (req_sync != pos_r.ack_tgl) begin
      pos_nxt.latest  = sys_r.held; // stable while the request is open
      pos_nxt.ack_tgl = req_sync;
    end
    pos_nxt.word[0] = conv[ADCPO_SAMPLE_W-1:0]; // new conversion each edge
    pos_nxt.overrange_flag[0]  = conv[ADCPO_SAMPLE_W];
    for (int i = 1; i < ADCPO_LATENCY; i++) begin
      pos_nxt.word[i] = pos_r.word[i-1];
      pos_nxt.overrange_flag[i]  = pos_r.overrange_flag[i-1];  // flag travels with its word
    end
    pos_nxt.rise_tgl = neg_r.fall_tgl; // strobe goes low
  end

  always_ff @(posedge samp_clk_i or posedge link_rst) begin
    if (link_rst) begin
      pos_r <= '{ack_tgl: 1'b0, latest: ADCPO_INPUT_RST,
                 word: {ADCPO_LATENCY{ADCPO_WORD_RST}},
                 overrange_flag: '0, rise_tgl: 1'b0};
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // falling edge: word and flag update together with the strobe rise
  always_comb begin
    neg_nxt          = neg_r;
    neg_nxt.word     = pos_r.word[ADCPO_LATENCY-1];
    neg_nxt.overrange_flag      = pos_r.overrange_flag[ADCPO_LATENCY-1];
    neg_nxt.fall_tgl = ~pos_r.rise_tgl;             // strobe goes high
  end

  always_ff @(negedge samp_clk_i or posedge link_rst) begin
    if (link_rst) begin
      neg_r <= '{word: ADCPO_WORD_RST, overrange_flag: 1'b0, fall_tgl: 1'b0};
    end else begin
      neg_r <= neg_nxt;
    end
  end

  // bit order is the natural vector order, lsb on bit 0
  assign sample_word_o    = neg_r.word;
  assign overrange_flag_o = neg_r.overrange_flag;
  // the two edge toggles differ only during clock low, so the strobe is an
  // inverted copy of the clock; one xor trades glitch-free timing for no
  // extra clock, and it holds for any duty cycle
  assign word_valid_strobe_o = pos_r.rise_tgl ^ neg_r.fall_tgl;

endmodule // adcpo_output_if

//--- adcpo_output_if_chk.sv
module adcpo_chk (
  // clocks and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        samp_clk_i,
  // watched outputs
  input wire logic [12:0] sample_word_o,
  input wire logic        overrange_flag_o,
  input wire logic        word_valid_strobe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] go_r;
  logic       run;
  // link edges since reset; the link reset lags, so strobe checks wait
  always_ff @(posedge samp_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      go_r <= 4'h0;
    end else if (go_r != 4'hF) begin
      go_r <= go_r + 4'h1;
    end
  end
  assign run = (go_r >= 4'h4);
  sequence s_hi; word_valid_strobe_o; endsequence
  sequence s_lo; !word_valid_strobe_o; endsequence
  default clocking cb @(samp_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_strobe_inverse: assert property (run |-> word_valid_strobe_o == !samp_clk_i)
    else $error("strobe not inverse of clock");
  a_strobe_cycle: assert property (run && !samp_clk_i |-> s_hi ##1 s_lo)
    else $error("strobe missed a low phase");
  a_word_fall_edge: assert property (run && $changed(sample_word_o) |-> !samp_clk_i)
    else $error("word changed on rising edge");
  a_ovr_fall_edge: assert property (run && $changed(overrange_flag_o) |-> !samp_clk_i)
    else $error("flag changed on rising edge");
  a_word_with_strobe: assert property (run && $changed(sample_word_o) |-> s_hi)
    else $error("word changed without strobe rise");
  a_ovr_at_limit: assert property (overrange_flag_o |->
    sample_word_o == 13'h0000 || sample_word_o == 13'h1FFF)
    else $error("flag set on inner code");
  a_fill_zero: assert property (go_r < 4'h3 |->
    sample_word_o == 13'h0000 && !overrange_flag_o)
    else $error("data before pipeline filled");
  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    sys_rst_i && $past(sys_rst_i) |-> !word_valid_strobe_o && sample_word_o == 13'h0000)
    else $error("outputs active in reset");
endmodule // adcpo_chk

//--- adcpo_rx.sv
module adcpo_rx (
  // reset and strobe
  input  wire logic        sys_rst_i,
  input  wire logic        word_valid_strobe_i,
  // data in, captures out
  input  wire logic [12:0] word_i,
  input  wire logic        ovr_i,
  output logic      [12:0] cap_word_o,
  output logic             cap_ovr_o,
  output logic      [7:0]  cap_cnt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // capture on the strobe fall, one clock low phase after each update, word and flag as one pair
  // the count lets the bench relate captures to sampling edges
  always_ff @(negedge word_valid_strobe_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_cnt_o  <= 8'h00;
      cap_word_o <= 13'h0000;
      cap_ovr_o  <= 1'b0;
    end else begin
      cap_cnt_o  <= cap_cnt_o + 8'h01;
      cap_word_o <= word_i;
      cap_ovr_o  <= ovr_i;
    end
  end
endmodule // adcpo_rx

//--- adcpo_output_if_bench.sv
module adcpo_output_if_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic signed [15:0] a; logic [12:0] w; logic o;} adcpo_row_t;
  // reset starts low so that its first rise is a real edge for the async flops
  logic               clk_i = 0, sys_rst_i = 0, samp_clk_i = 0, overrange_flag, stb, cap_ovr;
  logic signed [15:0] ain_r = 16'sh0000;
  logic        [12:0] word, cap_word;
  logic        [7:0]  cap_cnt;
  int                 error_cnt = 0, n_checks = 0, n;
  adcpo_row_t rows[9] = '{
    '{16'sh0000, 13'h1000, 1'b0}, '{16'sh0001, 13'h1001, 1'b0},
    '{16'shFFFF, 13'h0FFF, 1'b0}, '{16'sh0FFF, 13'h1FFF, 1'b0},
    '{16'shF000, 13'h0000, 1'b0}, '{16'sh1000, 13'h1FFF, 1'b1},
    '{16'shEFFF, 13'h0000, 1'b1}, '{16'sh7FFF, 13'h1FFF, 1'b1},
    '{16'sh8000, 13'h0000, 1'b1}};
  adcpo_output_if u_adcpo_output_if (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .analog_input_pair_i(ain_r), .samp_clk_i(samp_clk_i), .sample_word_o(word),
    .overrange_flag_o(overrange_flag), .word_valid_strobe_o(stb));
  adcpo_rx u_adcpo_rx (.sys_rst_i(sys_rst_i), .word_valid_strobe_i(stb), .word_i(word),
    .ovr_i(overrange_flag), .cap_word_o(cap_word), .cap_ovr_o(cap_ovr), .cap_cnt_o(cap_cnt));
  // link clock starts off phase and never meets a rising edge of the system clock;
  // 48 ns with a 30 ns high phase, so the strobe is tried off half duty
  initial begin
    #7;
    forever begin
      #18 samp_clk_i = 1'b1;
      #30 samp_clk_i = 1'b0;
    end
  end
  initial begin forever #12.5 clk_i = ~clk_i; end
  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // wait for k captures; a dead strobe ends the run
  task caps(input int k);
    logic [7:0] c;
    c = cap_cnt + 8'(k);
    for (int t = 0; t < 8 * k && cap_cnt !== c; t++) @(posedge clk_i);
    if (cap_cnt !== c) begin
      error_cnt++;
      $display("ERROR capture count expected %0d seen %0d", c, cap_cnt);
      test_done;
    end
  endtask
  task do_reset;
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("rst word", 16'(word), 16'h0000);
    chk("rst strobe", 16'({overrange_flag, stb}), 16'h0000);
    sys_rst_i <= 1'b0;
    $display("test reset done");
  endtask
  initial begin
    do_reset;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      ain_r <= rows[i].a;
      caps(14);
      chk("word", 16'(cap_word), 16'(rows[i].w));
      chk("ovr", 16'(cap_ovr), 16'(rows[i].o));
    end
    $display("test rows done");
    @(posedge clk_i);
    ain_r <= 16'sh0005;
    n = 0;
    while (n < 14 && cap_word !== 13'h1005) begin caps(1); n++; end
    // four pipeline edges plus the input crossing: at least eight and at most
    // thirteen more sampling edges, depending on where the handshake stands
    chk("latency", 16'(n >= 8 && n <= 13), 16'h0001);
    $display("test latency done");
    do_reset;
    caps(14);
    chk("word after reset", 16'(cap_word), 16'h1005);
    $display("test restart done");
    test_done;
  end
endmodule // adcpo_output_if_bench
bind adcpo_output_if adcpo_chk u_adcpo_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .samp_clk_i(samp_clk_i), .sample_word_o(sample_word_o),
  .overrange_flag_o(overrange_flag_o), .word_valid_strobe_o(word_valid_strobe_o));
